/* logic/bec_regs.svh */
// Named constants for the boot entry and exit configuration command block
`ifndef BEC_REGS_SVH
`define BEC_REGS_SVH

// Link address and command frame codes
`define BEC_I2C_ADDR8    8'hAA
`define BEC_FAM_CFG_WR   8'h82
`define BEC_FAM_CFG_RD   8'h83
`define BEC_FAM_IDENT    8'hFF
`define BEC_IDX_PIN      8'h01
`define BEC_IDX_EXIT     8'h02
`define BEC_IDX_IDENT    8'h00
`define BEC_SUB_LEVEL    8'h02
`define BEC_SUB_POLICY   8'h00
`define BEC_SUB_TMO      8'h01
`define BEC_SUB_NONE     8'h00
`define BEC_LEN_WR       3'h4
`define BEC_LEN_RD       3'h3
`define BEC_LEN_ID       3'h2
`define BEC_LEN_MAX      3'h7
`define BEC_LVL_MAX      8'h01
`define BEC_POL_MAX      8'h02

// Response codes and lengths
`define BEC_ST_OK        8'h00
`define BEC_ST_ERR       8'h80
`define BEC_RSP_FILL     8'hFF
`define BEC_RSP_ONE      2'h1
`define BEC_RSP_TWO      2'h2

// Reset values of the configuration and exit policies
`define BEC_LVL_RST      1'b0
`define BEC_POL_RST      2'h0
`define BEC_TMO_RST      8'h00
`define BEC_POL_APPVALID 2'h0
`define BEC_POL_DELAY    2'h1

// Timing: step and fixed delay in ms, clock period in ns
`define BEC_STEP_MS      10
`define BEC_FIX_MS       50
`define BEC_CLK_NS       4
`define BEC_NS_PER_MS    1000000
`define BEC_STEP_CYC     (`BEC_STEP_MS * `BEC_NS_PER_MS / `BEC_CLK_NS)
`define BEC_FIX_TICKS    8'(`BEC_FIX_MS / `BEC_STEP_MS)
`define BEC_EVAL_CYC     2'h3
`define BEC_BITS_BYTE    4'h8

// Wishbone register offsets and field positions
`define BEC_REG_CTRL     8'h00
`define BEC_REG_STAT     8'h04
`define BEC_REG_CFG      8'h08
`define BEC_CTRL_APPV    0
`define BEC_STAT_BOOT    0
`define BEC_STAT_APP     1
`define BEC_STAT_BYPIN   2
`define BEC_STAT_PEND    3
`define BEC_STAT_SPENT   4
`define BEC_CFG_LVL      0
`define BEC_CFG_POL_LO   8
`define BEC_CFG_POL_HI   9
`define BEC_CFG_TMO_LO   16
`define BEC_CFG_TMO_HI   23

`endif

/* logic/bec_pkg.sv */
// Types shared by the boot entry and exit configuration command block
package bec_pkg;

   typedef enum logic [2:0] {BEC_X_EVAL, BEC_X_BOOT, BEC_X_DELAY, BEC_X_FIXED, BEC_X_APP} bec_exit_e;

   typedef enum logic [1:0] {BEC_L_IDLE, BEC_L_ADDR, BEC_L_WR, BEC_L_RD} bec_link_e;

   typedef struct packed {
      logic       act_lvl;
      logic [1:0] policy;
      logic [7:0] tmo;
   } bec_cfg_s;

   typedef struct packed {
      logic [7:0] fam;
      logic [7:0] idx;
      logic [7:0] sub;
      logic [7:0] dat;
      logic [2:0] len;
   } bec_cmd_s;

   typedef struct packed {
      logic       rx_vld;
      logic [7:0] rx_byte;
      logic       wr_start;
      logic       wr_stop;
      logic       tx_take;
      logic       busy;
   } bec_lnk_s;

endpackage : bec_pkg

/* logic/bec_i2c_target.sv */
// I2C target byte engine: pin synchronisers, start/stop detection, byte shifting
`timescale 1ns/1ps
`include "bec_regs.svh"
module bec_i2c_target
   import bec_pkg::*;
(
   input  wire logic       clk_i,      // System clock
   input  wire logic       rst_i,      // Synchronous reset, active high
   input  wire logic       scl_i,      // SCL pin level
   input  wire logic       sda_i,      // SDA pin level
   input  wire logic [7:0] tx_byte_i,  // Next byte to return on a read
   output logic            sda_o,      // SDA drive value, always low
   output logic            sda_oe_o,   // SDA pull-low enable
   output bec_lnk_s        lnk_o       // Byte events for the command logic
);
   localparam logic [6:0] ADDR7 = 7'(`BEC_I2C_ADDR8 >> 1);

   logic [1:0] scl_sync_ff;
   logic [1:0] sda_sync_ff;
   logic       scl_d_ff;
   logic       sda_d_ff;
   bec_link_e  st_ff;
   logic [3:0] cnt_ff;
   logic [7:0] sh_ff;
   logic       ack_ff;
   bec_lnk_s   ev_ff;
   logic       scl_s;
   logic       sda_s;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;
   logic       addr_hit;
   logic       byte_full;

   // Pins cross in through two flops; only the second flop is ever read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scl_sync_ff <= 2'h3;
         sda_sync_ff <= 2'h3;
         scl_d_ff    <= 1'b1;
         sda_d_ff    <= 1'b1;
      end else begin
         scl_sync_ff <= {scl_sync_ff[0], scl_i};
         sda_sync_ff <= {sda_sync_ff[0], sda_i};
         scl_d_ff    <= scl_s;
         sda_d_ff    <= sda_s;
      end
   end

   // Edge and condition decode on synchronised levels
   assign scl_s     = scl_sync_ff[1];
   assign sda_s     = sda_sync_ff[1];
   assign scl_rise  = scl_s & ~scl_d_ff;
   assign scl_fall  = ~scl_s & scl_d_ff;
   assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
   assign stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
   assign addr_hit  = (sh_ff[7:1] == ADDR7);
   assign byte_full = (cnt_ff == `BEC_BITS_BYTE);

   // Bit engine; SDA only changes after SCL falls so the controller never sees a false start
   always_ff @(posedge clk_i) begin
      ev_ff <= '0;
      if (rst_i) begin
         st_ff    <= BEC_L_IDLE;
         cnt_ff   <= 4'h0;
         sh_ff    <= 8'h00;
         ack_ff   <= 1'b0;
         sda_oe_o <= 1'b0;
      end else if (start_det) begin
         st_ff    <= BEC_L_ADDR;
         cnt_ff   <= 4'h0;
         ack_ff   <= 1'b0;
         sda_oe_o <= 1'b0;
      end else if (stop_det) begin
         ev_ff.wr_stop <= (st_ff == BEC_L_WR);
         st_ff         <= BEC_L_IDLE;
         ack_ff        <= 1'b0;
         sda_oe_o      <= 1'b0;
      end else if (scl_rise && st_ff != BEC_L_IDLE) begin
         if (!byte_full) begin
            sh_ff  <= {sh_ff[6:0], sda_s};
            cnt_ff <= 4'(cnt_ff + 4'h1);
         end else if (st_ff == BEC_L_RD && !ack_ff) begin
            if (sda_s) begin
               st_ff <= BEC_L_IDLE;          // Controller NACK ends the read
            end else begin
               ack_ff <= 1'b1;
            end
         end
      end else if (scl_fall && st_ff != BEC_L_IDLE) begin
         if (ack_ff) begin
            ack_ff <= 1'b0;
            cnt_ff <= 4'h0;
            if (st_ff == BEC_L_RD) begin
               sh_ff         <= tx_byte_i;
               sda_oe_o      <= ~tx_byte_i[7];
               ev_ff.tx_take <= 1'b1;
            end else begin
               sda_oe_o <= 1'b0;
            end
         end else if (byte_full && st_ff == BEC_L_ADDR) begin
            if (addr_hit) begin
               ack_ff         <= 1'b1;
               sda_oe_o       <= 1'b1;
               st_ff          <= sh_ff[0] ? BEC_L_RD : BEC_L_WR;
               ev_ff.wr_start <= ~sh_ff[0];
            end else begin
               st_ff <= BEC_L_IDLE;
            end
         end else if (byte_full && st_ff == BEC_L_WR) begin
            ack_ff        <= 1'b1;
            sda_oe_o      <= 1'b1;
            ev_ff.rx_vld  <= 1'b1;
            ev_ff.rx_byte <= sh_ff;
         end else if (st_ff == BEC_L_RD) begin
            sda_oe_o <= ~byte_full & ~sh_ff[7];
         end
      end
   end

   // Open-drain: the data value is a constant low, only the enable moves
   always_ff @(posedge clk_i) begin
      sda_o <= 1'b0;
   end

   // Busy from a start until a stop, a read NACK or an address byte for another target
   always_comb begin
      lnk_o      = ev_ff;
      lnk_o.busy = (st_ff != BEC_L_IDLE);
   end

endmodule : bec_i2c_target

/* logic/bec_boot_ctrl.sv */
// Boot entry and exit configuration command handler with Wishbone status port
// Overview of operation
// - Command sets boot pin active level, default low
// - Command reads back boot pin active level
// - Policy zero: jump once valid application exists
// - Pin-entered boot waits for pin inactive under policy zero only
// - Policy two: never leave bootloader alone
// - Command reads back stored exit policy
// - Timeout in 10 ms steps plus 50 ms
// - Any command cancels a running timeout
// - Command reads timeout byte, reset value zero
// - Identity command returns status and type
// - Target answers at write address 0xAA
`timescale 1ns/1ps
`include "bec_regs.svh"
module bec_boot_ctrl
   import bec_pkg::*;
#(
   parameter int unsigned STEP_CYC = `BEC_STEP_CYC,  // Cycles per 10 ms step
   parameter logic [7:0]  MCU_TYPE = 8'h5A           // Part type code, arbitrary value
)(
   input  wire logic        clk_i,                   // System clock, 250 MHz
   input  wire logic        rst_i,                   // Power-on reset, synchronous, active high
   input  wire logic        scl_i,                   // I2C clock pin
   input  wire logic        sda_i,                   // I2C data pin level
   output logic             sda_o,                   // I2C data drive value
   output logic             sda_oe_o,                // I2C data pull-low enable
   input  wire logic        boot_entry_pin_i,        // Boot entry pin
   input  wire logic        external_reset_pin_n_i,  // External reset pin, active low
   input  wire logic        wb_cyc_i,                // Wishbone cycle
   input  wire logic        wb_stb_i,                // Wishbone strobe
   input  wire logic        wb_we_i,                 // Wishbone write enable
   input  wire logic [7:0]  wb_adr_i,                // Wishbone byte address
   input  wire logic [3:0]  wb_sel_i,                // Wishbone byte selects
   input  wire logic [31:0] wb_dat_i,                // Wishbone write data
   output logic [31:0]      wb_dat_o,                // Wishbone read data
   output logic             wb_ack_o,                // Wishbone acknowledge
   output logic             boot_mode_o,             // In bootloader mode
   output logic             app_mode_o               // Jumped to application
);
   localparam int DW = $clog2(STEP_CYC);

   bec_lnk_s     lnk;
   logic [7:0]   tx_byte;
   logic [1:0]   pin_sync_ff;
   logic [1:0]   rstp_sync_ff;
   bec_cfg_s     cfg_ff;
   bec_cmd_s     cmd_ff;
   logic [7:0]   rsp0_ff;
   logic [7:0]   rsp1_ff;
   logic [1:0]   rsp_len_ff;
   logic [1:0]   rsp_ptr_ff;
   logic         rsp_pend_ff;
   bec_exit_e    x_ff;
   logic         by_pin_ff;
   logic         spent_ff;
   logic [1:0]   eval_cnt_ff;
   logic [DW-1:0] div_ff;
   logic [7:0]   tick_cnt_ff;
   logic         appv_ff;

   // Decode of a collected frame against one command shape
   function automatic logic is_cmd(input bec_cmd_s c, input logic [7:0] f, input logic [7:0] i,
                                   input logic [7:0] s, input logic [2:0] n);
      is_cmd = (c.len == n) && (c.fam == f) && (c.idx == i) && (n < `BEC_LEN_RD || c.sub == s);
   endfunction : is_cmd

   // Link engine answers at its fixed target address
   bec_i2c_target u_link (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .scl_i     (scl_i),
      .sda_i     (sda_i),
      .tx_byte_i (tx_byte),
      .sda_o     (sda_o),
      .sda_oe_o  (sda_oe_o),
      .lnk_o     (lnk)
   );

   // Command decode
   logic cmd_done, w_lvl, w_pol, w_tmo, r_lvl, r_pol, r_tmo, r_id, cfg_wr, cmd_ok, is_rd;
   logic [7:0] rsp_dat;
   assign cmd_done = lnk.wr_stop && (cmd_ff.len != 3'h0);
   assign w_lvl    = is_cmd(cmd_ff, `BEC_FAM_CFG_WR, `BEC_IDX_PIN, `BEC_SUB_LEVEL, `BEC_LEN_WR)
                     && (cmd_ff.dat <= `BEC_LVL_MAX);
   assign w_pol    = is_cmd(cmd_ff, `BEC_FAM_CFG_WR, `BEC_IDX_EXIT, `BEC_SUB_POLICY, `BEC_LEN_WR)
                     && (cmd_ff.dat <= `BEC_POL_MAX);
   assign w_tmo    = is_cmd(cmd_ff, `BEC_FAM_CFG_WR, `BEC_IDX_EXIT, `BEC_SUB_TMO, `BEC_LEN_WR);
   assign r_lvl    = is_cmd(cmd_ff, `BEC_FAM_CFG_RD, `BEC_IDX_PIN, `BEC_SUB_LEVEL, `BEC_LEN_RD);
   assign r_pol    = is_cmd(cmd_ff, `BEC_FAM_CFG_RD, `BEC_IDX_EXIT, `BEC_SUB_POLICY, `BEC_LEN_RD);
   assign r_tmo    = is_cmd(cmd_ff, `BEC_FAM_CFG_RD, `BEC_IDX_EXIT, `BEC_SUB_TMO, `BEC_LEN_RD);
   assign r_id     = is_cmd(cmd_ff, `BEC_FAM_IDENT, `BEC_IDX_IDENT, `BEC_SUB_NONE, `BEC_LEN_ID);
   assign cfg_wr   = (cmd_ff.fam == `BEC_FAM_CFG_WR);
   assign is_rd    = r_lvl | r_pol | r_tmo | r_id;
   assign cmd_ok   = w_lvl | w_pol | w_tmo | is_rd;

   // Read-back data for the second response byte
   assign rsp_dat = r_lvl ? {7'h00, cfg_ff.act_lvl} :
                    r_pol ? {6'h00, cfg_ff.policy} :
                    r_tmo ? cfg_ff.tmo :
                    MCU_TYPE;

   // Bytes beyond the response read back as fill
   assign tx_byte = (rsp_ptr_ff >= rsp_len_ff) ? `BEC_RSP_FILL :
                    (rsp_ptr_ff == 2'h0) ? rsp0_ff : rsp1_ff;

   // Frame collection: family, index, sub-index, data; overlong frames fail the decode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_ff <= '0;
      end else if (lnk.wr_start) begin
         cmd_ff.len <= 3'h0;
      end else if (lnk.rx_vld && cmd_ff.len != `BEC_LEN_MAX) begin
         case (cmd_ff.len)
            3'h0: cmd_ff.fam <= lnk.rx_byte;
            3'h1: cmd_ff.idx <= lnk.rx_byte;
            3'h2: cmd_ff.sub <= lnk.rx_byte;
            3'h3: cmd_ff.dat <= lnk.rx_byte;
            default: ;
         endcase
         cmd_ff.len <= 3'(cmd_ff.len + 3'h1);
      end
   end

   // Configuration store; only power-on clears it, the external reset pin keeps it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_ff.act_lvl <= `BEC_LVL_RST;
         cfg_ff.policy  <= `BEC_POL_RST;
         cfg_ff.tmo     <= `BEC_TMO_RST;
      end else if (cmd_done) begin
         if (w_lvl) cfg_ff.act_lvl <= cmd_ff.dat[0];
         if (w_pol) cfg_ff.policy <= cmd_ff.dat[1:0];
         if (w_tmo) cfg_ff.tmo <= cmd_ff.dat;
      end
   end

   // Response buffer; a new command wins over a read pointer step in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rsp0_ff     <= `BEC_ST_OK;
         rsp1_ff     <= 8'h00;
         rsp_len_ff  <= 2'h0;
         rsp_ptr_ff  <= 2'h0;
         rsp_pend_ff <= 1'b0;
      end else begin
         if (lnk.tx_take) begin
            if (rsp_ptr_ff != 2'h3) rsp_ptr_ff <= 2'(rsp_ptr_ff + 2'h1);
            if (rsp_ptr_ff == 2'h0) rsp_pend_ff <= 1'b0;
         end
         if (cmd_done) begin
            rsp0_ff     <= cmd_ok ? `BEC_ST_OK : `BEC_ST_ERR;
            rsp1_ff     <= rsp_dat;
            rsp_len_ff  <= (cmd_ok && is_rd) ? `BEC_RSP_TWO : `BEC_RSP_ONE;
            rsp_ptr_ff  <= 2'h0;
            rsp_pend_ff <= cfg_wr;
         end
      end
   end

   // Boot pin and external reset pin synchronisers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_sync_ff  <= 2'h0;
         rstp_sync_ff <= 2'h3;                                       // Idle level: no false pin reset after power-up
      end else begin
         pin_sync_ff  <= {pin_sync_ff[0], boot_entry_pin_i};
         rstp_sync_ff <= {rstp_sync_ff[0], external_reset_pin_n_i};
      end
   end

   // Exit qualifiers
   logic pin_act, ext_rst, quiet, tmr_run, tick, tmr_zero;
   assign pin_act  = (pin_sync_ff[1] == cfg_ff.act_lvl);
   assign ext_rst  = ~rstp_sync_ff[1];
   assign quiet    = ~lnk.busy & ~rsp_pend_ff;
   assign tmr_run  = (x_ff == BEC_X_DELAY) || (x_ff == BEC_X_FIXED);
   assign tick     = tmr_run && (div_ff == DW'(STEP_CYC - 1));
   assign tmr_zero = (tick_cnt_ff == 8'h00);

   // 10 ms step divider, held at zero outside the timed states
   always_ff @(posedge clk_i) begin
      if (rst_i || !tmr_run || tick) begin
         div_ff <= '0;
      end else begin
         div_ff <= DW'(div_ff + 1'b1);
      end
   end

   // Exit state machine; the timers only start once the link is quiet
   always_ff @(posedge clk_i) begin
      if (rst_i || ext_rst) begin
         x_ff        <= BEC_X_EVAL;
         by_pin_ff   <= 1'b0;
         spent_ff    <= 1'b0;
         eval_cnt_ff <= 2'h0;
         tick_cnt_ff <= 8'h00;
      end else begin
         if (cmd_done && (w_pol || w_tmo)) spent_ff <= 1'b0;
         case (x_ff)
            BEC_X_EVAL: begin
               eval_cnt_ff <= 2'(eval_cnt_ff + 2'h1);
               if (eval_cnt_ff == `BEC_EVAL_CYC) begin
                  by_pin_ff <= pin_act;
                  x_ff      <= BEC_X_BOOT;
               end
            end
            BEC_X_BOOT: begin
               if (quiet && cfg_ff.policy == `BEC_POL_APPVALID) begin
                  if (appv_ff && !(by_pin_ff && pin_act)) begin
                     x_ff        <= BEC_X_FIXED;
                     tick_cnt_ff <= `BEC_FIX_TICKS;
                  end
               end else if (quiet && cfg_ff.policy == `BEC_POL_DELAY && !spent_ff && !cmd_done) begin
                  x_ff        <= BEC_X_DELAY;
                  tick_cnt_ff <= cfg_ff.tmo;
               end
               // Policy two never leaves this state by itself
            end
            BEC_X_DELAY: begin
               if (cmd_done || lnk.rx_vld) begin
                  x_ff     <= BEC_X_BOOT;
                  spent_ff <= 1'b1;
               end else if (tmr_zero) begin
                  if (appv_ff) begin
                     x_ff        <= BEC_X_FIXED;
                     tick_cnt_ff <= `BEC_FIX_TICKS;
                  end else begin
                     x_ff     <= BEC_X_BOOT;
                     spent_ff <= 1'b1;
                  end
               end else if (tick) begin
                  tick_cnt_ff <= 8'(tick_cnt_ff - 8'h01);
               end
            end
            BEC_X_FIXED: begin
               if ((cmd_done || lnk.rx_vld) && cfg_ff.policy == `BEC_POL_DELAY) begin
                  x_ff     <= BEC_X_BOOT;
                  spent_ff <= 1'b1;
               end else if (tmr_zero) begin
                  x_ff <= BEC_X_APP;
               end else if (tick) begin
                  tick_cnt_ff <= 8'(tick_cnt_ff - 8'h01);
               end
            end
            BEC_X_APP: ;
            default: x_ff <= BEC_X_EVAL;
         endcase
      end
   end

   // Mode outputs, registered one cycle behind the state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         boot_mode_o <= 1'b0;
         app_mode_o  <= 1'b0;
      end else begin
         boot_mode_o <= (x_ff != BEC_X_EVAL) && (x_ff != BEC_X_APP);
         app_mode_o  <= (x_ff == BEC_X_APP);
      end
   end

   // Wishbone decode; unmapped reads return zero and unmapped writes are dropped
   logic wb_req, sel_ctrl, sel_stat, sel_cfg;
   logic [31:0] rd_mux;
   assign wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign sel_ctrl = (wb_adr_i == `BEC_REG_CTRL);
   assign sel_stat = (wb_adr_i == `BEC_REG_STAT);
   assign sel_cfg  = (wb_adr_i == `BEC_REG_CFG);

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (sel_ctrl) rd_mux[`BEC_CTRL_APPV] = appv_ff;
      if (sel_stat) begin
         rd_mux[`BEC_STAT_BOOT]  = boot_mode_o;
         rd_mux[`BEC_STAT_APP]   = app_mode_o;
         rd_mux[`BEC_STAT_BYPIN] = by_pin_ff;
         rd_mux[`BEC_STAT_PEND]  = rsp_pend_ff;
         rd_mux[`BEC_STAT_SPENT] = spent_ff;
      end
      if (sel_cfg) begin
         rd_mux[`BEC_CFG_LVL]                      = cfg_ff.act_lvl;
         rd_mux[`BEC_CFG_POL_HI:`BEC_CFG_POL_LO]   = cfg_ff.policy;
         rd_mux[`BEC_CFG_TMO_HI:`BEC_CFG_TMO_LO]   = cfg_ff.tmo;
      end
   end

   // Single-wait-state slave: ack one cycle after the request, dropped the next
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         appv_ff  <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req) wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_mux;
         if (wb_req && wb_we_i && sel_ctrl && wb_sel_i[0]) appv_ff <= wb_dat_i[`BEC_CTRL_APPV];
      end
   end

endmodule : bec_boot_ctrl

/* test/bec_boot_ctrl_monitor.sv */
// Port checks for the boot configuration handler
`timescale 1ns/1ps
`include "bec_regs.svh"
module bec_boot_ctrl_monitor #(parameter int unsigned STEP_CYC = 20)(
   input wire logic        clk_i,                 // Clock
   input wire logic        rst_i,                 // Reset
   input wire logic        wb_cyc_i,              // Cycle
   input wire logic        wb_stb_i,              // Strobe
   input wire logic        wb_we_i,               // Write
   input wire logic [7:0]  wb_adr_i,              // Address
   input wire logic [31:0] wb_dat_o,              // Read data
   input wire logic        wb_ack_o,              // Ack
   input wire logic        boot_mode_o,           // Boot mode
   input wire logic        app_mode_o,            // App mode
   input wire logic        external_reset_pin_n_i // Ext reset
);
   localparam int FIX_MIN = 5 * STEP_CYC - 2;
   logic [15:0] boot_cnt_ff;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Length of the current boot stay; saturates so a long stay never wraps
   always_ff @(posedge clk_i) begin
      if (rst_i || !boot_mode_o) boot_cnt_ff <= 16'h0000;
      else if (boot_cnt_ff != 16'hFFFF) boot_cnt_ff <= boot_cnt_ff + 16'h0001;
   end
   a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_ack_caused: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i > `BEC_REG_CFG
      |=> wb_dat_o == 32'h00000000) else $error("unmapped read not zero");
   a_modes_apart: assert property (!(boot_mode_o && app_mode_o))
      else $error("both modes set");
   a_app_sticky: assert property (external_reset_pin_n_i [*4] ##0 app_mode_o |=> app_mode_o)
      else $error("app mode dropped");
   a_app_from_boot: assert property ($rose(app_mode_o) |-> $past(boot_mode_o))
      else $error("app entered not from boot");
   a_fixed_wait: assert property ($rose(app_mode_o) |-> boot_cnt_ff >= FIX_MIN)
      else $error("fixed delay too short");
endmodule : bec_boot_ctrl_monitor
bind bec_boot_ctrl bec_boot_ctrl_monitor #(.STEP_CYC(STEP_CYC)) mon_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .boot_mode_o, .app_mode_o, .external_reset_pin_n_i);

/* test/bec_i2c_host.sv */
// Behavioural I2C host controller facing the handler
`timescale 1ns/1ps
module bec_i2c_host (
   output logic     scl_o,  // Clock, idle high
   output logic     pull_o, // High pulls SDA low
   input wire logic sda_i   // Resolved wire level
);
   initial begin
      scl_o = 1'b1;
      pull_o = 1'b0;
   end
   // One 48 ns bit slot; SDA only moves while SCL is low
   task automatic bit_x(input logic b, output logic r);
      pull_o = ~b;
      #12 scl_o = 1'b1;
      #24 r = sda_i;
      scl_o = 1'b0;
      #12;
   endtask : bit_x
   task automatic byte_x(input logic [7:0] b, input logic ma, output logic [7:0] r, output logic ta);
      for (int i = 7; i >= 0; i--) bit_x(b[i], r[i]);
      bit_x(~ma, ta);
      ta = ~ta;
   endtask : byte_x
   // Write frame to 0xAA, then status and data read at 0xAB; odd start delay drifts phase
   task automatic cmd(input logic [7:0] q[$], output logic [7:0] st, output logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic a;
      ok = 1'b1;
      for (int f = 0; f < 2; f++) begin
         #13 pull_o = 1'b1;
         #12 scl_o = 1'b0;
         byte_x(f ? 8'hAB : 8'hAA, 1'b0, r, a);
         ok &= a;
         if (f == 0) begin
            foreach (q[i]) begin
               byte_x(q[i], 1'b0, r, a);
               ok &= a;
            end
         end else begin
            byte_x(8'hFF, 1'b1, st, a);
            byte_x(8'hFF, 1'b0, d, a);
         end
         pull_o = 1'b1;
         #12 scl_o = 1'b1;
         #12 pull_o = 1'b0;
      end
   endtask : cmd
endmodule : bec_i2c_host

/* test/test_bec_boot_ctrl.sv */
// Self-checking bench for the boot configuration handler
`timescale 1ns/1ps
`include "bec_regs.svh"
module test_bec_boot_ctrl;
   import bec_pkg::*;
   localparam int STEP = 20;
   localparam logic [7:0] TYPE_ID = 8'h3C; // Part type code, arbitrary value
   logic clk_i = 1'b0, rst_i = 1'b1, pin = 1'b1, ext_n = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic ack, boot, app, scl, pull, sda_o, sda_oe;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat;
   int err_total = 0, n_tests = 0;
   wire sda = ~(pull | sda_oe);
   always #2 clk_i = ~clk_i;
   bec_i2c_host h_u (.scl_o(scl), .pull_o(pull), .sda_i(sda));
   bec_boot_ctrl #(.STEP_CYC(STEP), .MCU_TYPE(TYPE_ID)) dut_u (.clk_i, .rst_i, .scl_i(scl), .sda_i(sda), .sda_o,
      .sda_oe_o(sda_oe), .boot_entry_pin_i(pin), .external_reset_pin_n_i(ext_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .boot_mode_o(boot), .app_mode_o(app));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n = 0;
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      do @(posedge clk_i); while (ack !== 1'b1 && ++n < 50);
      r = rdat;
      {cyc, stb} <= 2'b00;
      chk("wb_ack", 1'b1, ack);
   endtask : wb
   task automatic cmd(input logic [7:0] q[$], input logic [7:0] est, output logic [7:0] d);
      logic [7:0] st;
      logic ok;
      h_u.cmd(q, st, d, ok);
      chk("target_ack", 1'b1, ok);
      chk("status", est, st);
   endtask : cmd
   // Application must not appear before lo cycles, then within hi more
   task automatic win(input int lo, input int hi);
      repeat (lo) @(posedge clk_i);
      chk("app_early", 1'b0, app);
      repeat (hi) if (app !== 1'b1) @(posedge clk_i);
      chk("app_mode", 1'b1, app);
   endtask : win
   task automatic ext_rst();
      @(posedge clk_i) ext_n <= 1'b0;
      repeat (4) @(posedge clk_i);
      ext_n <= 1'b1;
   endtask : ext_rst
   task automatic t_cfg();
      logic [7:0] t [5][5] = '{'{8'h01, 8'h02, 8'h01, 8'h00, 8'h01}, '{8'h02, 8'h00, 8'h02, 8'h00, 8'h02},
         '{8'h02, 8'h01, 8'hFF, 8'h00, 8'hFF}, '{8'h01, 8'h02, 8'h02, 8'h80, 8'h01},
         '{8'h02, 8'h00, 8'h03, 8'h80, 8'h02}};
      logic [7:0] d;
      logic [31:0] r;
      cmd({8'h83, 8'h02, 8'h01}, 8'h00, d);
      chk("tmo_reset", 8'h00, d);
      cmd({8'h83, 8'h01, 8'h02}, 8'h00, d);
      chk("lvl_reset", 8'h00, d);
      foreach (t[i]) begin
         cmd({8'h82, t[i][0], t[i][1], t[i][2]}, t[i][3], d);
         cmd({8'h83, t[i][0], t[i][1]}, 8'h00, d);
         chk("readback", t[i][4], d);
      end
      cmd({8'hFF, 8'h00}, 8'h00, d);
      chk("mcu_type", TYPE_ID, d);
      wb(1'b0, `BEC_REG_CFG, 32'h0, r);
      chk("cfg_reg", 32'h00FF0201, r);
      wb(1'b0, 8'h40, 32'h0, r);
      chk("unmapped", 32'h0, r);
   endtask : t_cfg
   task automatic t_exit();
      logic [7:0] d;
      logic [31:0] r;
      wb(1'b1, `BEC_REG_CTRL, 32'h1, r);
      repeat (400) @(posedge clk_i);
      chk("stay", 1'b0, app);
      cmd({8'h82, 8'h02, 8'h00, 8'h00}, 8'h00, d);
      ext_rst(); // Pin high is the active level now
      repeat (400) @(posedge clk_i);
      chk("pin_hold", 1'b0, app);
      pin <= 1'b0;
      win(5 * STEP - 10, 60);
      cmd({8'h82, 8'h02, 8'h00, 8'h01}, 8'h00, d);
      ext_rst();
      repeat (20) @(posedge clk_i); // The timeout only starts once the link is quiet
      cmd({8'hFF, 8'h00}, 8'h00, d); // Lands inside the long timeout
      repeat (6000) @(posedge clk_i);
      chk("cancel", 1'b0, app);
      wb(1'b0, `BEC_REG_STAT, 32'h0, r);
      chk("stat_spent", 32'h00000011, r);
      cmd({8'h82, 8'h02, 8'h01, 8'h02}, 8'h00, d);
      ext_rst();
      win(7 * STEP - 10, 60);
      wb(1'b0, `BEC_REG_CFG, 32'h0, r);
      chk("cfg_kept", 32'h00020101, r);
   endtask : t_exit
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      chk("boot_mode", 1'b1, boot);
      chk("sda_o", 1'b0, sda_o);
      t_cfg();
      t_exit();
      report_and_stop();
   end
   // Watchdog well above the expected run of about 21000 cycles
   initial begin
      #300_000;
      err_total++;
      report_and_stop();
   end
endmodule : test_bec_boot_ctrl
